// ### rtl/ima_pkg.sv
package ima_pkg;

  // ****************************************************************
  // bus carriers
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ima_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ima_apb_rsp_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ima_pin_out_t;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h0C;

  // sequence_control_reg fields
  localparam int CTL_EN = 0;
  localparam int CTL_IE = 1;
  localparam int CTL_START = 2;
  localparam int CTL_RSTART = 3;
  localparam int CTL_STOP = 4;
  localparam int CTL_ACK = 5;
  localparam int CTL_ACKDATA = 6;

  // port_status_reg fields
  localparam int ST_COLL = 0;
  localparam int ST_EVT = 1;
  localparam int ST_BF = 2;
  localparam int ST_START = 3;
  localparam int ST_STOP = 4;
  localparam int ST_ACKSTAT = 5;
  localparam int ST_FREE = 6;
  localparam int ST_BUSY = 7;
  localparam int ST_WCOL = 8;

  localparam int RELOAD_W = 7;
  localparam int BYTE_W = 8;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 7'h04;
  localparam logic [BYTE_W-1:0] BUF_RST = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  // bit-period counter advances once every four system clocks
  localparam logic [1:0] BRG_PRE_LAST = 2'h3;
  localparam logic [3:0] BYTE_MSB = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum {
    S_IDLE,
    S_ST_A, S_ST_B,
    S_RS_A, S_RS_B, S_RS_C, S_RS_D,
    S_SP_A, S_SP_B, S_SP_C, S_SP_D,
    S_ACK_A, S_ACK_B, S_ACK_C,
    S_TX_A, S_TX_B, S_TX_C
  } ima_state_t;

endpackage

// ### rtl/ima_brg.sv
`timescale 1ns/100ps
module ima_brg (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic run,
  input wire logic [ima_pkg::RELOAD_W-1:0] reload,
  output logic done
);
  import ima_pkg::*;

  logic [1:0] pre_reg;
  logic [RELOAD_W-1:0] cnt_reg;
  logic tick;

  assign tick = (pre_reg == BRG_PRE_LAST);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pre_reg <= 2'h0;
    end else if (load || !run) begin
      pre_reg <= 2'h0;
    end else begin
      pre_reg <= pre_reg + 2'h1;
    end
  end

  // frozen whenever run is low and load is not set, so a stretched clock stalls the count
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= reload;
    end else if (run && tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= run && tick && !load && cnt_reg == '0;
    end
  end

endmodule

// ### rtl/ima_top.sv
`timescale 1ns/100ps
// Summary of operation
// - on SCL release, counter waits for SCL high, then reloads and counts
// - every master-driven SCL high phase lasts at least one full count
// - in sleep the port keeps working and wakes the core if enabled
// - reset or disable stops the port and aborts any transfer
// - start/stop seen flags clear on reset or disable; they define bus free
// - stop seen while bus busy raises the event flag and interrupt
// - own released one read back low at SCL high is a collision
// - arbitration is checked in address, data, start, restart and ack phases
// - collision in a byte halts it, clears buffer full, frees lines
// - collision in a sequence aborts it, frees lines, clears sequence bits
// - after a collision a stop on the bus sets the event flag
// - next buffer write after a collision starts from the first bit
// - start with SDA or SCL already low aborts with collision
// - start: SDA high loads counter; SCL low with SDA high collides
// - SDA low in first start count reloads and drives SDA at once
// - otherwise SDA low at count end, second count, then SCL low
// - restart: free SDA, count, free SCL; SDA low at SCL high collides
// - other party pulling SDA low in restart count is no collision
// - SCL falling in restart count before SDA driven low collides
// - both high at timeout: SDA low, count, then SCL low
// - stop: SCL high then count; SDA low after its count collides
// - SCL low in stop before SDA is released collides
module ima_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ima_pkg::ima_apb_req_t apb_req,
  output ima_pkg::ima_apb_rsp_t apb_rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  output ima_pkg::ima_pin_out_t pins,
  input wire logic sleep_mode,
  output logic port_irq,
  output logic wake_req
);
  import ima_pkg::*;

  // ****************************************************************
  // pin synchronisers and bus condition detect
  // ****************************************************************
  logic scl_meta, scl_s, scl_q;
  logic sda_meta, sda_s, sda_q;
  logic start_det, stop_det;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_s <= scl_meta;
      scl_q <= scl_s;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      sda_q <= sda_s;
    end
  end

  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;

  // ****************************************************************
  // state and register declarations
  // ****************************************************************
  ima_state_t state_reg;
  logic scl_drv_reg, sda_drv_reg;
  logic [3:0] bit_idx_reg;
  logic brg_load_reg, brg_run, brg_done;
  logic coll_p_reg, evt_p_reg, seq_clr_reg, bf_clr_reg, ack_p_reg, ack_val_reg;
  logic ctl_en_reg, ctl_ie_reg, ctl_start_reg, ctl_rstart_reg, ctl_stop_reg;
  logic ctl_ack_reg, ctl_ackdata_reg;
  logic [RELOAD_W-1:0] reload_reg;
  logic [BYTE_W-1:0] shift_buf_reg;
  logic coll_reg, evt_reg, bf_reg, start_seen_reg, stop_seen_reg;
  logic ack_stat_reg, wcol_reg;
  logic bus_free, idle_ok, start_req, lost, tx_bit;
  logic [2:0] bit_sel;
  logic [DATA_W-1:0] ctrl_word, status_word, prdata_reg;
  logic apb_setup, apb_acc, addr_ok, wr_ctrl, wr_reload, wr_status, wr_data;
  logic data_ok;

  assign bus_free = stop_seen_reg || (!start_seen_reg && !stop_seen_reg);
  // one-cycle guard: completion pulses reach the control bits an edge later
  assign idle_ok = (state_reg == S_IDLE) && !seq_clr_reg && !bf_clr_reg;
  assign start_req = idle_ok && ctl_en_reg && ctl_start_reg && bus_free;
  assign bit_sel = 3'(BYTE_MSB - bit_idx_reg);
  assign tx_bit = (bit_idx_reg == BIT_ACK) ? 1'b1 : shift_buf_reg[bit_sel];

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_acc = apb_req.psel && apb_req.penable;
  assign addr_ok = (apb_req.paddr == OFS_CTRL) || (apb_req.paddr == OFS_RELOAD) ||
                   (apb_req.paddr == OFS_STATUS) || (apb_req.paddr == OFS_DATA);
  assign wr_ctrl = apb_acc && apb_req.pwrite && apb_req.paddr == OFS_CTRL;
  assign wr_reload = apb_acc && apb_req.pwrite && apb_req.paddr == OFS_RELOAD;
  assign wr_status = apb_acc && apb_req.pwrite && apb_req.paddr == OFS_STATUS;
  assign wr_data = apb_acc && apb_req.pwrite && apb_req.paddr == OFS_DATA;
  assign data_ok = wr_data && idle_ok && !bf_reg && ctl_en_reg;

  assign apb_rsp.pready = apb_acc;
  assign apb_rsp.pslverr = apb_acc && !addr_ok;
  assign apb_rsp.prdata = prdata_reg;

  always_comb begin
    ctrl_word = WORD_ZERO;
    ctrl_word[CTL_EN] = ctl_en_reg;
    ctrl_word[CTL_IE] = ctl_ie_reg;
    ctrl_word[CTL_START] = ctl_start_reg;
    ctrl_word[CTL_RSTART] = ctl_rstart_reg;
    ctrl_word[CTL_STOP] = ctl_stop_reg;
    ctrl_word[CTL_ACK] = ctl_ack_reg;
    ctrl_word[CTL_ACKDATA] = ctl_ackdata_reg;
    status_word = WORD_ZERO;
    status_word[ST_COLL] = coll_reg;
    status_word[ST_EVT] = evt_reg;
    status_word[ST_BF] = bf_reg;
    status_word[ST_START] = start_seen_reg;
    status_word[ST_STOP] = stop_seen_reg;
    status_word[ST_ACKSTAT] = ack_stat_reg;
    status_word[ST_FREE] = bus_free;
    status_word[ST_BUSY] = (state_reg != S_IDLE);
    status_word[ST_WCOL] = wcol_reg;
  end

  // read data captured in the setup phase so the access phase needs no wait
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= WORD_ZERO;
    end else if (apb_setup) begin
      case (apb_req.paddr)
        OFS_CTRL: prdata_reg <= ctrl_word;
        OFS_RELOAD: prdata_reg <= DATA_W'(reload_reg);
        OFS_STATUS: prdata_reg <= status_word;
        OFS_DATA: prdata_reg <= DATA_W'(shift_buf_reg);
        default: prdata_reg <= WORD_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // control and data registers
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_en_reg <= 1'b0;
      ctl_ie_reg <= 1'b0;
      ctl_ackdata_reg <= 1'b0;
      ctl_start_reg <= 1'b0;
      ctl_rstart_reg <= 1'b0;
      ctl_stop_reg <= 1'b0;
      ctl_ack_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctl_en_reg <= apb_req.pwdata[CTL_EN];
        ctl_ie_reg <= apb_req.pwdata[CTL_IE];
        ctl_ackdata_reg <= apb_req.pwdata[CTL_ACKDATA];
      end
      if (!ctl_en_reg || seq_clr_reg) begin
        ctl_start_reg <= 1'b0;
        ctl_rstart_reg <= 1'b0;
        ctl_stop_reg <= 1'b0;
        ctl_ack_reg <= 1'b0;
      end else if (wr_ctrl && idle_ok) begin
        // no queueing: sequence bits are only taken while idle
        ctl_start_reg <= apb_req.pwdata[CTL_START];
        ctl_rstart_reg <= apb_req.pwdata[CTL_RSTART];
        ctl_stop_reg <= apb_req.pwdata[CTL_STOP];
        ctl_ack_reg <= apb_req.pwdata[CTL_ACK];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reload_reg <= RELOAD_RST;
    end else if (wr_reload) begin
      reload_reg <= apb_req.pwdata[RELOAD_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_buf_reg <= BUF_RST;
    end else if (data_ok) begin
      shift_buf_reg <= apb_req.pwdata[BYTE_W-1:0];
    end
  end

  // ****************************************************************
  // status flags: hardware set wins over software clear
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      coll_reg <= 1'b0;
      evt_reg <= 1'b0;
      wcol_reg <= 1'b0;
    end else begin
      if (coll_p_reg) begin
        coll_reg <= 1'b1;
      end else if (wr_status && apb_req.pwdata[ST_COLL]) begin
        coll_reg <= 1'b0;
      end
      if (evt_p_reg || (stop_det && start_seen_reg && ctl_en_reg)) begin
        evt_reg <= 1'b1;
      end else if (wr_status && apb_req.pwdata[ST_EVT]) begin
        evt_reg <= 1'b0;
      end
      if (wr_data && !data_ok) begin
        wcol_reg <= 1'b1;
      end else if (wr_status && apb_req.pwdata[ST_WCOL]) begin
        wcol_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bf_reg <= 1'b0;
    end else if (data_ok) begin
      bf_reg <= 1'b1;
    end else if (bf_clr_reg || !ctl_en_reg) begin
      bf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (!ctl_en_reg) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (start_det) begin
      start_seen_reg <= 1'b1;
      stop_seen_reg <= 1'b0;
    end else if (stop_det) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack_stat_reg <= 1'b0;
    end else if (ack_p_reg) begin
      ack_stat_reg <= ack_val_reg;
    end
  end

  // interrupt keeps running in sleep, so a finished byte can wake the core
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      port_irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      port_irq <= ctl_ie_reg && (coll_reg || evt_reg);
      wake_req <= ctl_ie_reg && sleep_mode && (coll_reg || evt_reg);
    end
  end

  // ****************************************************************
  // bit-period counter
  // ****************************************************************
  // wait states (SCL released, not yet seen high) leave it stopped
  always_comb begin
    case (state_reg)
      S_ST_A, S_ST_B, S_RS_A, S_RS_C, S_RS_D, S_SP_A, S_SP_C, S_SP_D,
      S_ACK_A, S_ACK_C, S_TX_A, S_TX_C: brg_run = 1'b1;
      default: brg_run = 1'b0;
    endcase
  end

  ima_brg u_brg (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(brg_load_reg),
    .run(brg_run),
    .reload(reload_reg),
    .done(brg_done)
  );

  // ****************************************************************
  // arbitration loss per state
  // ****************************************************************
  always_comb begin
    case (state_reg)
      S_IDLE: lost = start_req && (!sda_s || !scl_s);
      S_ST_A: lost = sda_s && !scl_s;
      S_RS_B: lost = scl_s && !sda_s;
      S_RS_C: lost = sda_s && !scl_s;
      S_SP_C: lost = !scl_s;
      S_SP_D: lost = brg_done && !sda_s;
      S_ACK_C: lost = !sda_drv_reg && !sda_s;
      S_TX_C: lost = !sda_drv_reg && !sda_s && bit_idx_reg != BIT_ACK;
      default: lost = 1'b0;
    endcase
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      bit_idx_reg <= 4'h0;
      brg_load_reg <= 1'b0;
      coll_p_reg <= 1'b0;
      evt_p_reg <= 1'b0;
      seq_clr_reg <= 1'b0;
      bf_clr_reg <= 1'b0;
      ack_p_reg <= 1'b0;
      ack_val_reg <= 1'b0;
    end else begin
      brg_load_reg <= 1'b0;
      coll_p_reg <= 1'b0;
      evt_p_reg <= 1'b0;
      seq_clr_reg <= 1'b0;
      bf_clr_reg <= 1'b0;
      ack_p_reg <= 1'b0;
      if (!ctl_en_reg) begin
        state_reg <= S_IDLE;
        scl_drv_reg <= 1'b0;
        sda_drv_reg <= 1'b0;
        bit_idx_reg <= 4'h0;
      end else if (lost) begin
        state_reg <= S_IDLE;
        scl_drv_reg <= 1'b0;
        sda_drv_reg <= 1'b0;
        bit_idx_reg <= 4'h0;
        coll_p_reg <= 1'b1;
        seq_clr_reg <= 1'b1;
        bf_clr_reg <= 1'b1;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (start_req) begin
              brg_load_reg <= 1'b1;
              state_reg <= S_ST_A;
            end else if (idle_ok && ctl_rstart_reg) begin
              sda_drv_reg <= 1'b0;
              brg_load_reg <= 1'b1;
              state_reg <= S_RS_A;
            end else if (idle_ok && ctl_stop_reg) begin
              sda_drv_reg <= 1'b1;
              brg_load_reg <= 1'b1;
              state_reg <= S_SP_A;
            end else if (idle_ok && ctl_ack_reg) begin
              scl_drv_reg <= 1'b1;
              sda_drv_reg <= !ctl_ackdata_reg;
              brg_load_reg <= 1'b1;
              state_reg <= S_ACK_A;
            end else if (idle_ok && bf_reg) begin
              scl_drv_reg <= 1'b1;
              brg_load_reg <= 1'b1;
              state_reg <= S_TX_A;
            end
          end
          S_ST_A: begin
            if (!sda_s || brg_done) begin
              sda_drv_reg <= 1'b1;
              brg_load_reg <= 1'b1;
              state_reg <= S_ST_B;
            end
          end
          S_ST_B: begin
            if (brg_done) begin
              scl_drv_reg <= 1'b1;
              seq_clr_reg <= 1'b1;
              evt_p_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          S_RS_A: begin
            if (brg_done) begin
              scl_drv_reg <= 1'b0;
              state_reg <= S_RS_B;
            end
          end
          S_RS_B: begin
            if (scl_s) begin
              brg_load_reg <= 1'b1;
              state_reg <= S_RS_C;
            end
          end
          S_RS_C: begin
            if (!sda_s || brg_done) begin
              sda_drv_reg <= 1'b1;
              brg_load_reg <= 1'b1;
              state_reg <= S_RS_D;
            end
          end
          S_RS_D: begin
            if (brg_done) begin
              scl_drv_reg <= 1'b1;
              seq_clr_reg <= 1'b1;
              evt_p_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          S_SP_A: begin
            if (brg_done) begin
              scl_drv_reg <= 1'b0;
              state_reg <= S_SP_B;
            end
          end
          S_SP_B: begin
            if (scl_s) begin
              brg_load_reg <= 1'b1;
              state_reg <= S_SP_C;
            end
          end
          S_SP_C: begin
            if (brg_done) begin
              sda_drv_reg <= 1'b0;
              brg_load_reg <= 1'b1;
              state_reg <= S_SP_D;
            end
          end
          S_SP_D: begin
            if (brg_done) begin
              seq_clr_reg <= 1'b1;
              evt_p_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          S_ACK_A: begin
            if (brg_done) begin
              scl_drv_reg <= 1'b0;
              state_reg <= S_ACK_B;
            end
          end
          S_ACK_B: begin
            if (scl_s) begin
              brg_load_reg <= 1'b1;
              state_reg <= S_ACK_C;
            end
          end
          S_ACK_C: begin
            if (brg_done) begin
              scl_drv_reg <= 1'b1;
              seq_clr_reg <= 1'b1;
              evt_p_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          S_TX_A: begin
            // data changes only while SCL is held low
            sda_drv_reg <= !tx_bit;
            if (brg_done) begin
              scl_drv_reg <= 1'b0;
              state_reg <= S_TX_B;
            end
          end
          S_TX_B: begin
            if (scl_s) begin
              brg_load_reg <= 1'b1;
              state_reg <= S_TX_C;
            end
          end
          S_TX_C: begin
            if (brg_done) begin
              scl_drv_reg <= 1'b1;
              brg_load_reg <= 1'b1;
              if (bit_idx_reg == BIT_ACK) begin
                ack_p_reg <= 1'b1;
                ack_val_reg <= sda_s;
                evt_p_reg <= 1'b1;
                bit_idx_reg <= 4'h0;
                sda_drv_reg <= 1'b0;
                state_reg <= S_IDLE;
              end else begin
                bf_clr_reg <= (bit_idx_reg == BYTE_MSB);
                bit_idx_reg <= bit_idx_reg + 4'h1;
                state_reg <= S_TX_A;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // open drain: pins only ever pull low
  assign pins.scl_o = 1'b0;
  assign pins.scl_oe = scl_drv_reg;
  assign pins.sda_o = 1'b0;
  assign pins.sda_oe = sda_drv_reg;

endmodule

// ### bench/ima_bus_model.sv
`timescale 1ns/100ps
module ima_bus_model (
  input wire logic clk_sys,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic sda_low,
  input wire logic scl_low,
  input wire logic stretch,
  output logic scl_in,
  output logic sda_in,
  output logic [7:0] rx_byte
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic ack_low = 1'b0;
  logic hold = 1'b0;
  int bit_n = 0;
  int hold_n = 0;
  // wired-and with pull-ups
  assign scl_in = !(scl_oe | hold | scl_low);
  assign sda_in = !(sda_oe | sda_low | ack_low);
  always @(posedge clk_sys) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (scl_q && sda_q && !sda_in) begin
      bit_n <= 0;
    end else if (!scl_q && scl_in) begin
      bit_n <= bit_n + 1;
      if (bit_n < 8) begin
        rx_byte <= {rx_byte[6:0], sda_in};
      end
    end
    if (scl_q && !scl_in) begin
      ack_low <= (bit_n == 8);
      if (bit_n == 9) begin
        bit_n <= 0;
      end
      // hold the clock low longer than any short low count
      hold <= stretch && scl_oe;
      hold_n <= 40;
    end else if (hold_n > 0) begin
      hold_n <= hold_n - 1;
    end else begin
      hold <= 0;
    end
  end
endmodule

// ### bench/ima_top_assertions.sv
`timescale 1ns/100ps
module ima_top_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ima_pkg::ima_apb_req_t apb_req,
  input wire ima_pkg::ima_apb_rsp_t apb_rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire ima_pkg::ima_pin_out_t pins,
  input wire logic sleep_mode,
  input wire logic port_irq,
  input wire logic wake_req
);
  import ima_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [6:0] rl_reg;
  logic [9:0] hi_reg;
  logic [2:0] wr_reg;
  wire acc = apb_req.psel & apb_req.penable;
  wire wr = acc & apb_req.pwrite;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rl_reg <= RELOAD_RST;
    end else if (wr && apb_req.paddr == OFS_RELOAD) begin
      rl_reg <= apb_req.pwdata[6:0];
    end
  end
  // raw SCL high time while released, saturating
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hi_reg <= 10'h000;
    end else if (pins.scl_oe || !scl_in) begin
      hi_reg <= 10'h000;
    end else if (hi_reg != 10'h3FF) begin
      hi_reg <= hi_reg + 10'h001;
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= 3'h0;
    end else begin
      wr_reg <= {wr_reg[1:0], wr && (apb_req.paddr == OFS_CTRL || apb_req.paddr == OFS_STATUS)};
    end
  end
  sequence s_start_drive;
    $rose(pins.sda_oe) && !pins.scl_oe;
  endsequence
  sequence s_scl_pull;
    $rose(pins.scl_oe);
  endsequence
  a_ready_zero_wait: assert property (acc |-> apb_rsp.pready)
    else $error("access phase without ready");
  a_unmapped_err: assert property (acc && apb_req.paddr > OFS_DATA |->
    apb_rsp.pslverr && apb_rsp.prdata == WORD_ZERO) else $error("unmapped access not refused");
  a_open_drain_low: assert property (!pins.scl_o && !pins.sda_o)
    else $error("pin driven high");
  a_reset_lines_free: assert property ($fell(sys_rst) |->
    !pins.scl_oe && !pins.sda_oe && !port_irq) else $error("lines or irq active after reset");
  a_wake_in_sleep: assert property (wake_req |-> port_irq && $past(sleep_mode))
    else $error("wake without irq in sleep");
  a_start_scl_high: assert property (s_start_drive |-> $past(scl_in, 4))
    else $error("start drove sda with scl low");
  a_scl_high_min: assert property (s_scl_pull |->
    hi_reg >= ({3'h0, rl_reg} + 10'h001) * 4) else $error("scl high phase too short");
  a_irq_sticky: assert property ($fell(port_irq) |-> |wr_reg)
    else $error("irq dropped without software");
endmodule
bind ima_top ima_top_assertions u_chk (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .pins(pins),
  .sleep_mode(sleep_mode),
  .port_irq(port_irq),
  .wake_req(wake_req)
);

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ima_pkg::*;
  logic clk_sys = 0;
  logic sys_rst = 1;
  logic sleep_mode = 0;
  logic sda_low = 0;
  logic scl_low = 0;
  logic stretch = 1;
  ima_apb_req_t req = '0;
  ima_apb_rsp_t rsp;
  ima_pin_out_t pins;
  logic scl_in, sda_in, port_irq, wake_req, e;
  logic [7:0] rx;
  logic [31:0] r, v;
  int failures = 0;
  int checked = 0;
  int seed = 47003;
  ima_top u_ima_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .scl_in(scl_in), .sda_in(sda_in), .pins(pins), .sleep_mode(sleep_mode),
    .port_irq(port_irq), .wake_req(wake_req));
  ima_bus_model u_ima_bus_model (.clk_sys(clk_sys), .scl_oe(pins.scl_oe),
    .sda_oe(pins.sda_oe), .sda_low(sda_low), .scl_low(scl_low), .stretch(stretch),
    .scl_in(scl_in), .sda_in(sda_in), .rx_byte(rx));
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) failures++;
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wt(input int b);
    int n;
    n = 0;
    do begin
      apb(0, OFS_STATUS, 0);
      n++;
    end while (r[b] !== 1'b1 && n < 500);
    chk({31'h0, r[b]}, 32'h1);
  endtask
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 0;
    apb(0, OFS_RELOAD, 0);
    chk(r, 32'h4);
    apb(0, OFS_STATUS, 0);
    chk(r, 32'h40);
    apb(0, 8'h10, 0);
    chk({e, r[30:0]}, 32'h8000_0000);
    v = $random(seed) & 32'h7F;
    apb(1, OFS_RELOAD, v);
    apb(0, OFS_RELOAD, 0);
    chk(r, v);
    // ****
    // short counts keep the run brief
    // ****
    apb(1, OFS_RELOAD, v & 32'h7);
    $display("register test done");
    apb(1, OFS_CTRL, 32'h3);
    apb(1, OFS_CTRL, 32'h7);
    wt(ST_EVT);
    apb(1, OFS_STATUS, 32'h2);
    v = $random(seed) & 32'hFF;
    apb(1, OFS_DATA, v);
    wt(ST_EVT);
    chk({24'h0, rx}, v);
    chk(r & 32'h24, 32'h0);
    apb(1, OFS_STATUS, 32'h2);
    apb(1, OFS_CTRL, 32'h13);
    wt(ST_EVT);
    chk(r & 32'h50, 32'h50);
    // own stop count outlasts the bus stop
    repeat (40) @(posedge clk_sys);
    $display("transfer test done");
    apb(1, OFS_STATUS, 32'h2);
    apb(1, OFS_CTRL, 32'h7);
    wt(ST_EVT);
    apb(1, OFS_STATUS, 32'h2);
    apb(1, OFS_DATA, 32'hFF);
    sda_low <= 1;
    wt(ST_COLL);
    chk(r & 32'h5, 32'h1);
    chk({30'h0, pins.scl_oe, pins.sda_oe}, 32'h0);
    apb(0, OFS_CTRL, 0);
    chk(r & 32'h3C, 32'h0);
    sleep_mode <= 1;
    repeat (4) @(posedge clk_sys);
    chk({30'h0, port_irq, wake_req}, 32'h3);
    sleep_mode <= 0;
    sda_low <= 0;
    wt(ST_EVT);
    apb(1, OFS_STATUS, 32'h103);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, port_irq}, 32'h0);
    apb(1, OFS_CTRL, 32'h7);
    wt(ST_EVT);
    apb(1, OFS_STATUS, 32'h2);
    apb(1, OFS_DATA, 32'hA5);
    wt(ST_EVT);
    chk({24'h0, rx}, 32'hA5);
    apb(1, OFS_STATUS, 32'h2);
    apb(1, OFS_CTRL, 32'hB);
    wt(ST_EVT);
    apb(1, OFS_STATUS, 32'h2);
    apb(1, OFS_CTRL, 32'h13);
    wt(ST_EVT);
    repeat (40) @(posedge clk_sys);
    $display("collision test done");
    scl_low <= 1;
    apb(1, OFS_CTRL, 32'h7);
    wt(ST_COLL);
    chk({30'h0, pins.scl_oe, pins.sda_oe}, 32'h0);
    scl_low <= 0;
    apb(1, OFS_STATUS, 32'h103);
    apb(1, OFS_CTRL, 32'h7);
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    apb(0, OFS_CTRL, 0);
    chk({r[30:0], pins.sda_oe}, 32'h0);
    $display("reset test done");
    stop_test;
  end
endmodule
